// ===== design/adc_sequencer_wait_for_read.v
/*
  Converter sequencer with wait-for-read double buffering. Holds the
  converter control register, the primary and injection result registers
  and the temporary latch, and drives the conversion core.
  Assumes a conversion core on the same clock that takes a one-cycle start
  with a channel and answers later with a one-cycle done and its sample,
  and a capture/compare event pulse on the same clock.
*/
// The strobed register port was chosen for this implementation.
// Notes on behaviour
// - Sixteen analog inputs, any one selectable as conversion source.
// - Four-bit channel code 0000..1111 selects inputs zero to fifteen.
// - Wait-for-read off: result written while unread raises overrun, old value lost.
// - Wait-for-read off, continuous or scan: next conversion starts at completion.
// - Control bit 9 selects wait-for-read double buffering through a temporary latch.
// - Wait-for-read, prior result read: write new result, start next conversion.
// - Wait-for-read, prior result unread: park result in latch, idle, no start.
// - Reading a stalled result moves latch in, raises complete, starts next.
// - Same stall handling after single or last conversion when software restarts.
// - Wait-for-read selected: overrun line pulses only on injection completion, never for an overrun.
// - Wait-for-read withholds starts while result full and new result pending.
// - Result-full flag set on each write, cleared by a read of it.
// - Busy and start stay set while stalled waiting for a result read.
// - Control register resets to zero; bits 15..12 and 6 reserved.
// - Bit 11 injection request, set by software or event, acts only when enabled.
// - Bit 10 enables channel injection.
// - Bit 8 busy reads one while a conversion is in progress.
// - Start bit 7, mode bits 5..4, channel select bits 3..0.
// - Primary result carries the converted channel number in its top four bits.
// - Injected result goes to second register, complete pulse on overrun line.
`default_nettype none

`include "adc_seq_defines.vh"

module adc_sequencer_wait_for_read
(
  // Clock and reset.
  input  wire                     mclk_i,
  input  wire                     srst_i,
  // Register port.
  input  wire [`ADDR_W-1:0]       addr_i,
  input  wire [`DATA_W-1:0]       wr_data_i,
  input  wire                     wr_i,
  input  wire                     rd_i,
  output wire [`DATA_W-1:0]       rd_data_o,
  // Conversion core.
  output wire                     conv_start_o,
  output wire [`CHAN_W-1:0]       conv_channel_o,
  input  wire                     conv_done_i,
  input  wire [`SAMPLE_W-1:0]     conv_sample_i,
  // Capture/compare channel 31 event.
  input  wire                     capcom_channel_31_event_i,
  // Interrupt requests.
  output wire                     conv_complete_irq_o,
  output wire                     overrun_irq_o
);

  // One-hot sequencer states.
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_CONV  = 4'h2;
  localparam [3:0] ST_STALL = 4'h4;
  localparam [3:0] ST_INJ   = 4'h8;

  //////////////////////////////////////////////////////////////////////////
  // State.

  reg  [3:0]               state_reg;
  reg  [`CHAN_W-1:0]       channel_select_reg;
  reg  [`MODE_W-1:0]       conversion_mode_reg;
  reg                      start_conversion_reg;
  reg                      converter_busy_reg;
  reg                      wait_for_read_reg;
  reg                      injection_enable_reg;
  reg                      injection_request_reg;
  reg  [`DATA_W-1:0]       primary_result_reg;
  reg  [`CHAN_W-1:0]       injection_chan_reg;
  reg  [`SAMPLE_W-1:0]     injection_sample_reg;
  reg  [`DATA_W-1:0]       temp_latch_reg;
  reg                      primary_full_reg;
  reg                      injection_full_reg;
  reg                      resume_reg;
  reg                      conv_start_reg;
  reg  [`CHAN_W-1:0]       conv_channel_reg;
  reg                      complete_irq_reg;
  reg                      overrun_irq_reg;
  reg  [`DATA_W-1:0]       rd_data_reg;

  wire [`CHAN_W-1:0]       step_chan;
  wire [`CHAN_W-1:0]       step_next_chan;
  wire                     step_series_end;

  //////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire ctl_wr   = wr_i && (addr_i == `ADDR_CONVERTER_CONTROL);
  wire inj_wr   = wr_i && (addr_i == `ADDR_INJECTION_RESULT);
  wire prim_rd  = rd_i && (addr_i == `ADDR_PRIMARY_RESULT);
  wire inj_rd   = rd_i && (addr_i == `ADDR_INJECTION_RESULT);
  wire sw_start = ctl_wr && wr_data_i[`CTL_START_BIT];

  // Injection runs only with both enable and wait-for-read set.
  wire inj_go = injection_enable_reg && injection_request_reg && wait_for_read_reg;

  // Completion of a normal conversion and what it leads to.
  wire norm_done  = state_reg[2'd1] && conv_done_i;
  wire park       = norm_done && wait_for_read_reg && primary_full_reg;
  wire norm_write = norm_done && !park;

  // A result is placed into the primary register either straight from the
  // core or out of the latch once software has read the stalled value.
  wire unstall      = state_reg[2'd2] && prim_rd;
  wire prim_write   = norm_write || unstall;
  wire inj_done     = state_reg[2'd3] && conv_done_i;

  // The sequence advances after a written normal result or after unstall.
  wire advance    = norm_write || unstall;
  wire advance_go = unstall ? (resume_reg || sw_start) : !step_series_end;

  // Resuming after an injection continues from where the series left off.
  wire inj_resume = inj_done && resume_reg;

  wire step_load    = state_reg[2'd0] && sw_start && !inj_go;
  wire step_advance = (advance && advance_go && !inj_go) || inj_resume;

  //////////////////////////////////////////////////////////////////////////
  // Channel stepper.

  scan_channel_stepper u_stepper
  (
    .mclk_i       (mclk_i),
    .srst_i       (srst_i),
    .load_i       (step_load),
    .load_chan_i  (wr_data_i[`CTL_CHAN_HI:`CTL_CHAN_LO]),
    .advance_i    (step_advance),
    .mode_i       (conversion_mode_reg),
    .select_i     (channel_select_reg),
    .chan_o       (step_chan),
    .next_chan_o  (step_next_chan),
    .series_end_o (step_series_end)
  );

  // Channel number on top, sample in the low bits.
  function [`DATA_W-1:0] pack_result;
    input [`CHAN_W-1:0]   chan;
    input [`SAMPLE_W-1:0] sample;
    begin
      pack_result = {chan, {`RES_PAD_W{1'b0}}, sample};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Control fields written by software.

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      channel_select_reg   <= `CHAN_RESET;
      conversion_mode_reg  <= `MODE_RESET;
      wait_for_read_reg    <= 1'b0;
      injection_enable_reg <= 1'b0;
      injection_chan_reg   <= `CHAN_RESET;
    end
    else
    begin
      if (ctl_wr)
      begin
        channel_select_reg   <= wr_data_i[`CTL_CHAN_HI:`CTL_CHAN_LO];
        conversion_mode_reg  <= wr_data_i[`CTL_MODE_HI:`CTL_MODE_LO];
        wait_for_read_reg    <= wr_data_i[`CTL_WFR_BIT];
        injection_enable_reg <= wr_data_i[`CTL_INJ_EN_BIT];
      end
      if (inj_wr)
      begin
        injection_chan_reg <= wr_data_i[`RES_CHAN_HI:`RES_CHAN_LO];
      end
    end
  end

  // The request is set by software or by the event even with injection
  // off, so software should clear it before enabling injection.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      injection_request_reg <= 1'b0;
    end
    else if (capcom_channel_31_event_i || (ctl_wr && wr_data_i[`CTL_INJ_REQ_BIT]))
    begin
      injection_request_reg <= 1'b1;
    end
    else if (inj_done || ctl_wr)
    begin
      injection_request_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Full flags; a new write in the same cycle as a read keeps the flag set.

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      primary_full_reg   <= 1'b0;
      injection_full_reg <= 1'b0;
    end
    else
    begin
      if (prim_write)
      begin
        primary_full_reg <= 1'b1;
      end
      else if (prim_rd)
      begin
        primary_full_reg <= 1'b0;
      end
      if (inj_done)
      begin
        injection_full_reg <= 1'b1;
      end
      else if (inj_rd)
      begin
        injection_full_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result registers and temporary latch.

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      primary_result_reg   <= `RESULT_RESET;
      temp_latch_reg       <= `RESULT_RESET;
      injection_sample_reg <= `SAMPLE_RESET;
    end
    else
    begin
      if (norm_write)
      begin
        primary_result_reg <= pack_result(step_chan, conv_sample_i);
      end
      else if (unstall)
      begin
        primary_result_reg <= temp_latch_reg;
      end
      if (park)
      begin
        temp_latch_reg <= pack_result(step_chan, conv_sample_i);
      end
      if (inj_done)
      begin
        injection_sample_reg <= conv_sample_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt pulses.

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      complete_irq_reg <= 1'b0;
      overrun_irq_reg  <= 1'b0;
    end
    else
    begin
      complete_irq_reg <= prim_write;
      // Overrun needs wait-for-read off; the line is free for injection.
      overrun_irq_reg  <= (norm_write && !wait_for_read_reg && primary_full_reg) || inj_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_reg            <= ST_IDLE;
      start_conversion_reg <= 1'b0;
      converter_busy_reg   <= 1'b0;
      resume_reg           <= 1'b0;
      conv_start_reg       <= 1'b0;
      conv_channel_reg     <= `CHAN_RESET;
    end
    else
    begin
      conv_start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (inj_go)
          begin
            state_reg          <= ST_INJ;
            converter_busy_reg <= 1'b1;
            resume_reg         <= 1'b0;
            conv_start_reg     <= 1'b1;
            conv_channel_reg   <= injection_chan_reg;
          end
          else if (sw_start)
          begin
            state_reg            <= ST_CONV;
            start_conversion_reg <= 1'b1;
            converter_busy_reg   <= 1'b1;
            conv_start_reg       <= 1'b1;
            conv_channel_reg     <= wr_data_i[`CTL_CHAN_HI:`CTL_CHAN_LO];
          end
        end
        ST_CONV:
        begin
          if (park)
          begin
            // Busy and start stay set through the stall.
            state_reg  <= ST_STALL;
            resume_reg <= !step_series_end;
          end
          else if (norm_write)
          begin
            if (advance_go && inj_go)
            begin
              state_reg        <= ST_INJ;
              resume_reg       <= 1'b1;
              conv_start_reg   <= 1'b1;
              conv_channel_reg <= injection_chan_reg;
            end
            else if (advance_go)
            begin
              conv_start_reg   <= 1'b1;
              conv_channel_reg <= step_next_chan;
            end
            else
            begin
              state_reg            <= ST_IDLE;
              start_conversion_reg <= 1'b0;
              converter_busy_reg   <= 1'b0;
            end
          end
        end
        ST_STALL:
        begin
          if (unstall)
          begin
            if (advance_go && inj_go)
            begin
              state_reg        <= ST_INJ;
              resume_reg       <= 1'b1;
              conv_start_reg   <= 1'b1;
              conv_channel_reg <= injection_chan_reg;
            end
            else if (advance_go)
            begin
              state_reg        <= ST_CONV;
              conv_start_reg   <= 1'b1;
              conv_channel_reg <= step_next_chan;
            end
            else
            begin
              state_reg            <= ST_IDLE;
              start_conversion_reg <= 1'b0;
              converter_busy_reg   <= 1'b0;
            end
          end
          else if (sw_start)
          begin
            resume_reg <= 1'b1;
          end
        end
        ST_INJ:
        begin
          if (inj_done && resume_reg)
          begin
            state_reg        <= ST_CONV;
            conv_start_reg   <= 1'b1;
            conv_channel_reg <= step_next_chan;
          end
          else if (inj_done)
          begin
            state_reg            <= ST_IDLE;
            start_conversion_reg <= 1'b0;
            converter_busy_reg   <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe.

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rd_data_reg <= `READ_ZERO;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `ADDR_CONVERTER_CONTROL:
        begin
          rd_data_reg <= {`RSV_HIGH_ZERO, injection_request_reg, injection_enable_reg,
                          wait_for_read_reg, converter_busy_reg, start_conversion_reg,
                          1'b0, conversion_mode_reg, channel_select_reg};
        end
        `ADDR_PRIMARY_RESULT:
        begin
          rd_data_reg <= primary_result_reg;
        end
        `ADDR_INJECTION_RESULT:
        begin
          rd_data_reg <= {injection_chan_reg, {`RES_PAD_W{1'b0}}, injection_sample_reg};
        end
        default:
        begin
          rd_data_reg <= `READ_ZERO;
        end
      endcase
    end
    else
    begin
      rd_data_reg <= `READ_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rd_data_o           = rd_data_reg;
  assign conv_start_o        = conv_start_reg;
  assign conv_channel_o      = conv_channel_reg;
  assign conv_complete_irq_o = complete_irq_reg;
  assign overrun_irq_o       = overrun_irq_reg;

endmodule

`default_nettype wire

// ===== design/scan_channel_stepper.v
/*
  Channel stepper of the converter sequencer. Holds the channel of the
  normal conversion in flight and works out the next channel and whether
  the current conversion closes its series.
  Assumes load and advance are never raised together and come from logic
  on the same clock.
*/
`default_nettype none

`include "adc_seq_defines.vh"

module scan_channel_stepper
(
  // Clock and reset.
  input  wire                     mclk_i,
  input  wire                     srst_i,
  // Stepping control.
  input  wire                     load_i,
  input  wire [`CHAN_W-1:0]       load_chan_i,
  input  wire                     advance_i,
  input  wire [`MODE_W-1:0]       mode_i,
  input  wire [`CHAN_W-1:0]       select_i,
  // Channel state.
  output wire [`CHAN_W-1:0]       chan_o,
  output wire [`CHAN_W-1:0]       next_chan_o,
  output wire                     series_end_o
);

  reg  [`CHAN_W-1:0]       chan_reg;
  reg  [`CHAN_W-1:0]       chan_next;

  //////////////////////////////////////////////////////////////////////////

  // Auto-scan walks down to channel zero; continuous single repeats the
  // channel that the select field holds now, so software may retarget it.
  always @*
  begin
    chan_next = select_i;
    if (mode_i == `MODE_SCAN_ONCE || mode_i == `MODE_SCAN_CONT)
    begin
      if (chan_reg != `CHAN_ZERO)
      begin
        chan_next = chan_reg - `CHAN_ONE;
      end
    end
  end

  assign next_chan_o  = chan_next;
  assign chan_o       = chan_reg;
  assign series_end_o = (mode_i == `MODE_SINGLE) ||
                        (mode_i == `MODE_SCAN_ONCE && chan_reg == `CHAN_ZERO);

  //////////////////////////////////////////////////////////////////////////

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      chan_reg <= `CHAN_RESET;
    end
    else if (load_i)
    begin
      chan_reg <= load_chan_i;
    end
    else if (advance_i)
    begin
      chan_reg <= chan_next;
    end
  end

endmodule

`default_nettype wire

// ===== include/adc_seq_defines.vh
/*
  Constants for the converter sequencer: register addresses, control field
  positions, reset values, mode codes and result layout.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// Register byte addresses.
`define ADDR_CONVERTER_CONTROL  16'hFFA0
`define ADDR_PRIMARY_RESULT     16'hFFA2
`define ADDR_INJECTION_RESULT   16'hFFA4

// Widths.
`define ADDR_W                  16
`define DATA_W                  16
`define CHAN_W                  4
`define MODE_W                  2
`define SAMPLE_W                10

// Control register field positions.
`define CTL_CHAN_LO             0
`define CTL_CHAN_HI             3
`define CTL_MODE_LO             4
`define CTL_MODE_HI             5
`define CTL_START_BIT           7
`define CTL_BUSY_BIT            8
`define CTL_WFR_BIT             9
`define CTL_INJ_EN_BIT          10
`define CTL_INJ_REQ_BIT         11

// Result register layout: channel number on top, sample in the low bits.
`define RES_CHAN_LO             12
`define RES_CHAN_HI             15
`define RES_SAMPLE_HI           9
`define RES_PAD_W               2

// Reset values.
`define CONTROL_RESET           16'h0000
`define RESULT_RESET            16'h0000
`define CHAN_RESET              4'h0
`define MODE_RESET              2'h0
`define SAMPLE_RESET            10'h000

// Conversion mode codes.
`define MODE_SINGLE             2'h0
`define MODE_CONT_SINGLE        2'h1
`define MODE_SCAN_ONCE          2'h2
`define MODE_SCAN_CONT          2'h3

// Constants met in the logic.
`define CHAN_ZERO               4'h0
`define CHAN_ONE                4'h1
`define READ_ZERO               16'h0000
`define RSV_HIGH_ZERO           4'h0

`endif

// ===== verification/adc_seq_checker.sv
/*
  Port checker for the converter sequencer, bound to its top module.
  Assumes one clock domain and the register map of the shared defines header.
*/
`default_nettype none

`include "adc_seq_defines.vh"

module adc_seq_checker
(
  // Clock and reset.
  input wire logic        mclk_i,
  input wire logic        srst_i,
  // Register port.
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rd_data_o,
  // Core and interrupts.
  input wire logic        conv_start_o,
  input wire logic        conv_done_i,
  input wire logic        conv_complete_irq_o,
  input wire logic        overrun_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow state; injected results are not tracked, so result checks stand
  // aside while injection is enabled.
  logic       wfr_s;
  logic       inj_s;
  logic       full_s;
  logic       stall_s;
  logic       out_s;
  logic [1:0] mode_s;
  wire        rd_pri = rd_i && addr_i == `ADDR_PRIMARY_RESULT;
  wire        rd_ctl = rd_i && addr_i == `ADDR_CONVERTER_CONTROL;

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      {wfr_s, inj_s, full_s, stall_s, out_s, mode_s} <= 7'h00;
    end
    else
    begin
      if (wr_i && addr_i == `ADDR_CONVERTER_CONTROL)
      begin
        {inj_s, wfr_s} <= wr_data_i[10:9];
        mode_s         <= wr_data_i[5:4];
      end
      full_s  <= conv_done_i | (full_s & ~rd_pri) | (stall_s & rd_pri);
      stall_s <= (conv_done_i & wfr_s & full_s) | (stall_s & ~rd_pri);
      out_s   <= conv_start_o | (out_s & ~conv_done_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence next_conv;
    conv_complete_irq_o && conv_start_o;
  endsequence

  sequence done_stop;
    conv_complete_irq_o && !conv_start_o;
  endsequence

  reset_quiet_a:
    assert property ($fell(srst_i) |-> !conv_start_o && !conv_complete_irq_o && !overrun_irq_o && rd_data_o == 16'h0000)
      else $error("outputs not quiet after reset");
  reserved_zero_a:
    assert property ($past(rd_ctl) |-> rd_data_o[15:12] == 4'h0 && !rd_data_o[6])
      else $error("reserved control bits not zero");
  single_flight_a:
    assert property (conv_start_o |-> !out_s)
      else $error("start while conversion outstanding");
  complete_cause_a:
    assert property (conv_complete_irq_o |-> $past(conv_done_i) || $past(rd_pri))
      else $error("complete pulse without cause");
  overrun_set_a:
    assert property (conv_done_i && !wfr_s && full_s |=> overrun_irq_o)
      else $error("overrun not raised");
  no_overrun_a:
    assert property (wfr_s && !inj_s |-> !overrun_irq_o)
      else $error("overrun in wait mode");
  cont_restart_a:
    assert property (conv_done_i && !wfr_s && mode_s == `MODE_CONT_SINGLE |=> next_conv)
      else $error("continuous restart missing");
  wait_free_a:
    assert property (conv_done_i && wfr_s && !full_s && !inj_s && mode_s[0] |=> next_conv)
      else $error("wait mode did not continue");
  stall_hold_a:
    assert property (conv_done_i && wfr_s && full_s && !inj_s |=> !conv_start_o [*8])
      else $error("start during stall");
  resume_read_a:
    assert property (rd_pri && stall_s && mode_s[0] && !inj_s |=> next_conv)
      else $error("no resume after read");
  single_stop_a:
    assert property (conv_done_i && mode_s == `MODE_SINGLE && !wfr_s && !inj_s |=> done_stop)
      else $error("single mode did not stop");
endmodule

bind adc_sequencer_wait_for_read adc_seq_checker u_chk
(
  .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
  .conv_complete_irq_o(conv_complete_irq_o), .overrun_irq_o(overrun_irq_o)
);

`default_nettype wire

// ===== verification/conv_core_model.sv
/*
  Behavioural conversion core answering the sequencer.
  Assumes one start pulse per conversion on the sequencer clock.
*/
`default_nettype none

module conv_core_model
#(
  parameter int LAT = 4
)
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // Conversion request.
  input  wire logic       start_i,
  input  wire logic [3:0] chan_i,
  // Conversion answer.
  output var  logic       done_o,
  output wire logic [9:0] sample_o
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // The sample encodes the channel; between answers the lines churn so that
  // a capture at the wrong cycle cannot match by luck.
  logic [3:0] chan_q = 4'h0;
  logic [9:0] junk   = 10'h000;
  int         cnt    = 0;

  assign sample_o = done_o ? {chan_q, chan_q, 2'h1} : junk;

  always @(posedge mclk_i)
  begin
    done_o <= 1'b0;
    junk   <= junk + 10'h0D3;
    if (srst_i)
      cnt <= 0;
    else if (start_i)
    begin
      cnt    <= LAT;
      chan_q <= chan_i;
    end
    else if (cnt == 1)
    begin
      done_o <= 1'b1;
      cnt    <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

`default_nettype wire

// ===== verification/test_adc_sequencer_wait_for_read.sv
/*
  Self-checking bench for the converter sequencer.
  Assumes the behavioural core model and the bound port checker.
*/
`default_nettype none

`include "adc_seq_defines.vh"

module test_adc_sequencer_wait_for_read;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] CTL = `ADDR_CONVERTER_CONTROL;
  localparam logic [15:0] PRI = `ADDR_PRIMARY_RESULT;
  localparam logic [15:0] INJ = `ADDR_INJECTION_RESULT;

  logic        mclk_i       = 1'b0;
  logic        srst_i       = 1'b1;
  logic [15:0] addr_i       = 16'h0000;
  logic [15:0] wr_data_i    = 16'h0000;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic        ev           = 1'b0;
  logic [15:0] rd_data_o;
  logic        conv_start_o;
  logic        conv_done_i;
  logic        cc_irq;
  logic        ov_irq;
  logic [3:0]  chan;
  logic [9:0]  sample;
  logic [3:0]  c;
  logic        seen;
  int          n_errors     = 0;
  int          total_checks = 0;
  int          n_starts     = 0;
  int          cycles       = 0;

  adc_sequencer_wait_for_read DUT
  (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .conv_start_o(conv_start_o), .conv_channel_o(chan), .conv_done_i(conv_done_i),
    .conv_sample_i(sample), .capcom_channel_31_event_i(ev), .conv_complete_irq_o(cc_irq), .overrun_irq_o(ov_irq)
  );

  conv_core_model core
  (
    .mclk_i(mclk_i), .srst_i(srst_i), .start_i(conv_start_o), .chan_i(chan), .done_o(conv_done_i), .sample_o(sample)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 mclk_i = ~mclk_i;

  // A hang ends the run as a mismatch instead of stalling the simulator.
  always @(posedge mclk_i)
  begin
    cycles++;
    if (conv_start_o === 1'b1)
      n_starts++;
    if (cycles == 5000)
    begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [15:0] res(input logic [3:0] ch);
    return {ch, 2'h0, ch, ch, 2'h1};
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, exp, rd_data_o);
  endtask

  task automatic wait_irq(input string nm, input logic ovr);
    seen = 1'b0;
    repeat (100)
    begin
      @(posedge mclk_i);
      #1;
      if ((ovr ? ov_irq : cc_irq) === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
    chk(nm, 16'h0001, {15'h0000, seen});
  endtask

  task automatic rst();
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    srst_i   <= 1'b0;
    n_starts = 0;
  endtask

  task automatic fire();
    @(posedge mclk_i);
    ev <= 1'b1;
    @(posedge mclk_i);
    ev <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst();
    rd_chk("ctl_reset", CTL, 16'h0000);
    wr(CTL, 16'hF04F);
    rd_chk("ctl_reserved", CTL, 16'h000F);
    rd_chk("unmapped", 16'hFFA6, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      wr(CTL, {12'h008, c});
      rd_chk("busy", CTL, {12'h018, c});
      wait_irq("single_irq", 1'b0);
      rd_chk("single_result", PRI, res(c));
    end
    rd_chk("idle", CTL, 16'h000F);
    wr(CTL, 16'h0093);
    wait_irq("overrun", 1'b1);
    rst();
    wr(CTL, 16'h02B1);
    wait_irq("wait_irq", 1'b0);
    repeat (40) @(posedge mclk_i);
    chk("stall_starts", 16'h0002, n_starts[15:0]);
    rd_chk("stall_ctl", CTL, 16'h03B1);
    rd_chk("old_result", PRI, res(4'h1));
    rd_chk("latched", PRI, res(4'h0));
    rst();
    wr(CTL, 16'h00A2);
    for (int i = 0; i < 3; i++)
    begin
      c = 4'h2 - i[3:0];
      wait_irq("scan_irq", 1'b0);
      rd_chk("scan_result", PRI, res(c));
    end
    rd_chk("scan_end", CTL, 16'h0022);
    rst();
    wr(INJ, 16'h7000);
    wr(CTL, 16'h0200);
    fire();
    repeat (20) @(posedge mclk_i);
    chk("no_inject", 16'h0000, n_starts[15:0]);
    rd_chk("req_held", CTL, 16'h0A00);
    wr(CTL, 16'h0600);
    fire();
    wait_irq("inj_irq", 1'b1);
    rd_chk("inj_result", INJ, res(4'h7));
    rd_chk("inj_ctl", CTL, 16'h0600);
    wr(CTL, 16'h0284);
    repeat (9) @(posedge mclk_i);
    wr(CTL, 16'h0285);
    repeat (9) @(posedge mclk_i);
    rd_chk("r9_old", PRI, res(4'h4));
    rd_chk("r9_new", PRI, res(4'h5));
    stop_test();
  end
endmodule

`default_nettype wire
